// ---- rtl/reset_init_consts.svh ----
`ifndef RESET_INIT_CONSTS_SVH
`define RESET_INIT_CONSTS_SVH

// register byte offsets
`define OFS_PORT_A_DIR     8'h00
`define OFS_PORT_A_LAT     8'h04
`define OFS_PORT_A_PIN     8'h08
`define OFS_PORT_STRIDE    8'h0c
`define OFS_PORT_E_DIR     8'h30
`define OFS_PORT_E_LAT     8'h34
`define OFS_PORT_E_PIN     8'h38
`define OFS_OSC_TUNE       8'h3c
`define OFS_TMR_PERIOD     8'h40
`define OFS_TMR_COUNT      8'h44
`define OFS_INT_CTRL       8'h48
`define OFS_PIR_FLAGS      8'h4c
`define OFS_PIR_ENABLE     8'h50
`define OFS_PIR_PRIO       8'h54
`define OFS_PROG_CNT       8'h58
`define OFS_TOS            8'h5c
`define OFS_STK_PTR        8'h60
`define OFS_EVT_STATUS     8'h64
`define OFS_EVT_MASK       8'h68
`define OFS_DIGITAL_EN     8'h6c

// field positions and masks
`define HIGH_GLOBAL_IRQ_ENABLE_BIT           7
`define LOW_GLOBAL_IRQ_ENABLE_BIT           6
`define WAKE_FLAG_BIT      0
`define PORT_A_OSC_MASK    8'hc0
`define PORT_A_ZERO_MASK   8'h2f
`define PORT_E_PIN3_BIT    3
`define OSC_TUNE_MASK      8'h3f
`define PIR_FLAGS_MASK     8'h7f
`define PIR_PRIO_MASK      8'h7f
`define EVT_MASK_BITS      8'h1f

// reset values
`define DIR_RESET          8'hff
`define PORT_E_DIR_RESET   3'h7
`define PIR_PRIO_RESET     8'h7f
`define TMR_PERIOD_RESET   16'hffff

// vectors and counts
`define VEC_HIGH           21'h000008
`define VEC_LOW            21'h000018
`define STACK_DEPTH_MAX    5'h1f

// event status bits
`define EVT_POWER_ON       0
`define EVT_WARM_RESET     1
`define EVT_WAKE_WDT       2
`define EVT_WAKE_IRQ       3
`define EVT_TMR_MATCH      4

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ---- rtl/reset_init_pkg.sv ----
package reset_init_pkg;

   typedef enum logic [2:0] {
      RC_NONE,
      RC_POWER_ON,
      RC_WARM,
      RC_WAKE_WDT,
      RC_WAKE_IRQ
   } reset_class_t;

   typedef struct packed {
      logic [3:0][7:0] dir;       // ports a..d direction, 1 = input
      logic [3:0][7:0] lat;       // ports a..d output latch
      logic [3:0][7:0] pin;       // ports a..d sampled pins
      logic [2:0]      e_dir;
      logic [2:0]      e_lat;
      logic [3:0]      e_pin;
      logic [7:0]      osc_tune;
      logic [15:0]     tmr_period;
      logic [15:0]     tmr_count;
      logic [7:0]      int_ctrl;
      logic [7:0]      pir_flags;
      logic [7:0]      pir_enable;
      logic [7:0]      pir_prio;
      logic [20:0]     prog_cnt;
      logic [20:0]     tos;
      logic [4:0]      stk_ptr;
      logic [7:0]      evt_status;
      logic [7:0]      evt_mask;
      logic            digital_en;
      logic            irq;
      logic            aw_held;
      logic [7:0]      aw_addr;
      logic            w_held;
      logic [31:0]     w_data;
      logic [3:0]      w_strb;
      logic            awready;
      logic            wready;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arready;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
   } state_t;

endpackage

// ---- rtl/reset_init_values_bank.sv ----
`include "reset_init_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module reset_init_values_bank #(
   parameter int ADDR_WIDTH = 8                   // axi byte address width
) (
   input  wire logic                  aclk,             // system clock
   input  wire logic                  aresetn,          // sync reset, low active
   input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,     // write address
   input  wire logic                  s_axi_awvalid,    // write address valid
   output logic                       s_axi_awready,    // write address ready
   input  wire logic [31:0]           s_axi_wdata,      // write data
   input  wire logic [3:0]            s_axi_wstrb,      // write byte strobes
   input  wire logic                  s_axi_wvalid,     // write data valid
   output logic                       s_axi_wready,     // write data ready
   output logic [1:0]                 s_axi_bresp,      // write response
   output logic                       s_axi_bvalid,     // write response valid
   input  wire logic                  s_axi_bready,     // write response ready
   input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,     // read address
   input  wire logic                  s_axi_arvalid,    // read address valid
   output logic                       s_axi_arready,    // read address ready
   output logic [31:0]                s_axi_rdata,      // read data
   output logic [1:0]                 s_axi_rresp,      // read response
   output logic                       s_axi_rvalid,     // read data valid
   input  wire logic                  s_axi_rready,     // read data ready
   input  wire logic                  power_on_reset,   // por or brown-out pulse
   input  wire logic                  warm_reset,       // pin/watchdog/instr/stack
   input  wire logic                  wake_watchdog,    // wake by watchdog pulse
   input  wire logic                  wake_interrupt,   // wake by interrupt pulse
   input  wire logic                  wake_irq_high,    // wake source is high prio
   input  wire logic [6:0]            wake_irq_source,  // peripheral flags to set
   input  wire logic                  osc_pins_enable,  // osc mode frees a[7:6]
   input  wire logic                  external_reset_pin_enable, // reset pin on e3
   input  wire logic [3:0][7:0]       port_pins_in,     // ports a..d pin levels
   input  wire logic [3:0]            port_e_pins_in,   // port e pin levels
   output logic [3:0][7:0]            port_direction,   // ports a..d, 1 = input
   output logic [3:0][7:0]            port_latch,       // ports a..d drive value
   output logic [2:0]                 port_e_direction, // port e, 1 = input
   output logic [2:0]                 port_e_latch,     // port e drive value
   output logic [20:0]                program_counter,  // core program counter
   output logic [4:0]                 return_stack_pointer, // stack pointer
   output logic                       irq               // level interrupt
);

   // elaboration check: the decode needs at least 7 address bits
   if (ADDR_WIDTH < 7 || ADDR_WIDTH > 32) begin : g_bad_addr_width
      $error("ADDR_WIDTH must lie in 7..32");
   end

   reset_init_pkg::state_t       st_reg;
   reset_init_pkg::state_t       st_next;
   reset_init_pkg::reset_class_t rclass;

   // byte-lane merge of an axi write into an old register value
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // index of a port a..d register group, 4 when not a port group
   function automatic logic [2:0] port_index(input logic [7:0] a);
      logic [2:0] r;
      r = 3'h4;
      for (int i = 0; i < 4; i++) begin
         if (a >= 8'(i) * `OFS_PORT_STRIDE && a < 8'(i + 1) * `OFS_PORT_STRIDE) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   // mask of bits that exist on port group i
   function automatic logic [7:0] port_mask(input logic [2:0] i, input logic osc_en);
      return (i == 3'h0 && !osc_en) ? ~`PORT_A_OSC_MASK : 8'hff;
   endfunction

   // reset class priority: power-on over warm over wake
   always_comb begin
      if (!aresetn || power_on_reset) begin
         rclass = reset_init_pkg::RC_POWER_ON;
      end else if (warm_reset) begin
         rclass = reset_init_pkg::RC_WARM;
      end else if (wake_interrupt) begin
         rclass = reset_init_pkg::RC_WAKE_IRQ;
      end else if (wake_watchdog) begin
         rclass = reset_init_pkg::RC_WAKE_WDT;
      end else begin
         rclass = reset_init_pkg::RC_NONE;
      end
   end

   // read decode, shared by the read channel
   function automatic logic [32:0] read_word(input reset_init_pkg::state_t s,
                                             input logic [7:0] a,
                                             input logic osc_en,
                                             input logic e3_en);
      logic [2:0]  pi;
      logic [7:0]  m;
      logic [7:0]  off;
      logic [31:0] d;
      logic        ok;
      pi  = port_index(a);
      m   = port_mask(pi, osc_en);
      d   = 32'h0;
      ok  = 1'b1;
      off = (pi < 3'h4) ? a - 8'(pi) * `OFS_PORT_STRIDE : a;
      if (a[1:0] != 2'h0) begin
         ok = 1'b0;
      end else if (pi < 3'h4) begin
         case (off)
            `OFS_PORT_A_DIR: d[7:0] = s.dir[pi[1:0]] & m;
            `OFS_PORT_A_LAT: d[7:0] = s.lat[pi[1:0]] & m;
            `OFS_PORT_A_PIN: begin
               d[7:0] = s.pin[pi[1:0]] & m;
               // analog-default bits stay zero until software frees them
               if (pi == 3'h0 && !s.digital_en) begin
                  d[7:0] = d[7:0] & ~`PORT_A_ZERO_MASK;
               end
            end
            default: ok = 1'b0;
         endcase
      end else begin
         case (a)
            `OFS_PORT_E_DIR: d[2:0]  = s.e_dir;
            `OFS_PORT_E_LAT: d[2:0]  = s.e_lat;
            `OFS_PORT_E_PIN: begin
               d[3:0] = s.e_pin;
               d[`PORT_E_PIN3_BIT] = s.e_pin[`PORT_E_PIN3_BIT] & ~e3_en;
            end
            `OFS_OSC_TUNE:   d[7:0]  = s.osc_tune & `OSC_TUNE_MASK;
            `OFS_TMR_PERIOD: d[15:0] = s.tmr_period;
            `OFS_TMR_COUNT:  d[15:0] = s.tmr_count;
            `OFS_INT_CTRL:   d[7:0]  = s.int_ctrl;
            `OFS_PIR_FLAGS:  d[7:0]  = s.pir_flags & `PIR_FLAGS_MASK;
            `OFS_PIR_ENABLE: d[7:0]  = s.pir_enable;
            `OFS_PIR_PRIO:   d[7:0]  = s.pir_prio & `PIR_PRIO_MASK;
            `OFS_PROG_CNT:   d[20:0] = s.prog_cnt;
            `OFS_TOS:        d[20:0] = s.tos;
            `OFS_STK_PTR:    d[4:0]  = s.stk_ptr;
            `OFS_EVT_STATUS: d[7:0]  = s.evt_status;
            `OFS_EVT_MASK:   d[7:0]  = s.evt_mask;
            `OFS_DIGITAL_EN: d[0]    = s.digital_en;
            default:         ok      = 1'b0;
         endcase
      end
      return {ok, d};
   endfunction

   // next-state logic for the whole bank
   always_comb begin
      logic [7:0]  wa;
      logic [31:0] wd;
      logic [31:0] cur;
      logic [2:0]  pi;
      logic [7:0]  m;
      logic [7:0]  off;
      logic [32:0] rw;
      logic        wr_ok;
      logic [7:0]  evt_set;
      logic [7:0]  evt_clr;
      wa      = st_reg.aw_addr;
      wd      = 32'h0;
      cur     = 32'h0;
      pi      = port_index(wa);
      m       = port_mask(pi, osc_pins_enable);
      off     = (pi < 3'h4) ? wa - 8'(pi) * `OFS_PORT_STRIDE : wa;
      rw      = 33'h0;
      wr_ok   = 1'b1;
      evt_set = 8'h0;
      evt_clr = 8'h0;
      st_next = st_reg;

      // pins sampled every cycle; inputs are synchronous
      st_next.pin   = port_pins_in;
      st_next.e_pin = port_e_pins_in;

      // free-running period timer
      if (st_reg.tmr_count == st_reg.tmr_period) begin
         st_next.tmr_count = 16'h0;
         evt_set[`EVT_TMR_MATCH] = 1'b1;
      end else begin
         st_next.tmr_count = st_reg.tmr_count + 16'h1;
      end

      // write channel: address and data taken in either order
      st_next.awready = 1'b0;
      st_next.wready  = 1'b0;
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.w_held = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
         st_next.aw_held = 1'b0;
         st_next.w_held  = 1'b0;
         st_next.bvalid  = 1'b1;
         if (wa[1:0] != 2'h0) begin
            wr_ok = 1'b0;
         end else if (pi < 3'h4) begin
            case (off)
               `OFS_PORT_A_DIR: begin
                  wd = merge({24'h0, st_reg.dir[pi[1:0]]}, st_reg.w_data, st_reg.w_strb);
                  st_next.dir[pi[1:0]] = (wd[7:0] & m) | (st_reg.dir[pi[1:0]] & ~m);
               end
               `OFS_PORT_A_LAT: begin
                  wd = merge({24'h0, st_reg.lat[pi[1:0]]}, st_reg.w_data, st_reg.w_strb);
                  st_next.lat[pi[1:0]] = (wd[7:0] & m) | (st_reg.lat[pi[1:0]] & ~m);
               end
               `OFS_PORT_A_PIN: ;                            // pins are read-only
               default: wr_ok = 1'b0;
            endcase
         end else begin
            case (wa)
               `OFS_PORT_E_DIR: cur = {29'h0, st_reg.e_dir};
               `OFS_PORT_E_LAT: cur = {29'h0, st_reg.e_lat};
               `OFS_OSC_TUNE:   cur = {24'h0, st_reg.osc_tune};
               `OFS_TMR_PERIOD: cur = {16'h0, st_reg.tmr_period};
               `OFS_TMR_COUNT:  cur = {16'h0, st_reg.tmr_count};
               `OFS_INT_CTRL:   cur = {24'h0, st_reg.int_ctrl};
               `OFS_PIR_FLAGS:  cur = {24'h0, st_reg.pir_flags};
               `OFS_PIR_ENABLE: cur = {24'h0, st_reg.pir_enable};
               `OFS_PIR_PRIO:   cur = {24'h0, st_reg.pir_prio};
               `OFS_EVT_MASK:   cur = {24'h0, st_reg.evt_mask};
               `OFS_DIGITAL_EN: cur = {31'h0, st_reg.digital_en};
               default:         cur = 32'h0;
            endcase
            wd = merge(cur, st_reg.w_data, st_reg.w_strb);
            case (wa)
               `OFS_PORT_E_DIR: st_next.e_dir      = wd[2:0];
               `OFS_PORT_E_LAT: st_next.e_lat      = wd[2:0];
               `OFS_OSC_TUNE:   st_next.osc_tune   = wd[7:0] & `OSC_TUNE_MASK;
               `OFS_TMR_PERIOD: st_next.tmr_period = wd[15:0];
               `OFS_TMR_COUNT:  st_next.tmr_count  = wd[15:0];
               `OFS_INT_CTRL:   st_next.int_ctrl   = wd[7:0];
               `OFS_PIR_FLAGS:  st_next.pir_flags  = wd[7:0] & `PIR_FLAGS_MASK;
               `OFS_PIR_ENABLE: st_next.pir_enable = wd[7:0];
               `OFS_PIR_PRIO:   st_next.pir_prio   = wd[7:0] & `PIR_PRIO_MASK;
               `OFS_EVT_MASK:   st_next.evt_mask   = wd[7:0] & `EVT_MASK_BITS;
               `OFS_DIGITAL_EN: st_next.digital_en = wd[0];
               // write one to clear; byte lane 0 only
               `OFS_EVT_STATUS: evt_clr = st_reg.w_strb[0] ? st_reg.w_data[7:0] : 8'h0;
               `OFS_PORT_E_PIN, `OFS_PROG_CNT, `OFS_TOS, `OFS_STK_PTR: ;  // read-only
               default:         wr_ok = 1'b0;
            endcase
         end
         st_next.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      // ready only while nothing of that kind is held or answered
      st_next.awready = !st_next.aw_held && !st_next.bvalid && !st_reg.awready;
      st_next.wready  = !st_next.w_held && !st_next.bvalid && !st_reg.wready;

      // read channel: one cycle from address to data
      st_next.arready = 1'b0;
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_reg.arready) begin
         rw = read_word(st_reg, 8'(s_axi_araddr), osc_pins_enable,
                        external_reset_pin_enable);
         st_next.rvalid = 1'b1;
         st_next.rdata  = rw[31:0];
         st_next.rresp  = rw[32] ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
         st_next.arready = !st_next.rvalid;
      end

      // power-on and warm classes override software writes of the same cycle
      case (rclass)
         reset_init_pkg::RC_POWER_ON: begin
            // unknown power-on contents are given as zero here
            st_next.dir        = {4{`DIR_RESET}};
            st_next.lat        = '0;
            st_next.e_dir      = `PORT_E_DIR_RESET;
            st_next.e_lat      = 3'h0;
            st_next.osc_tune   = 8'h0;
            st_next.tmr_period = `TMR_PERIOD_RESET;
            st_next.tmr_count  = 16'h0;
            st_next.int_ctrl   = 8'h0;
            st_next.pir_flags  = 8'h0;
            st_next.pir_enable = 8'h0;
            st_next.pir_prio   = `PIR_PRIO_RESET;
            st_next.prog_cnt   = 21'h0;
            st_next.tos        = 21'h0;
            st_next.stk_ptr    = 5'h0;
            st_next.digital_en = 1'b0;
            evt_set[`EVT_POWER_ON] = 1'b1;
         end
         reset_init_pkg::RC_WARM: begin
            // latches and stack top keep their contents; the timer count is not reset and keeps running
            st_next.dir        = {4{`DIR_RESET}};
            st_next.e_dir      = `PORT_E_DIR_RESET;
            st_next.osc_tune   = 8'h0;
            st_next.tmr_period = `TMR_PERIOD_RESET;
            st_next.int_ctrl   = 8'h0;
            st_next.pir_flags  = 8'h0;
            st_next.pir_enable = 8'h0;
            st_next.pir_prio   = `PIR_PRIO_RESET;
            st_next.prog_cnt   = 21'h0;
            st_next.stk_ptr    = 5'h0;
            st_next.digital_en = 1'b0;
            st_next.lat        = st_reg.lat;
            st_next.e_lat      = st_reg.e_lat;
            evt_set[`EVT_WARM_RESET] = 1'b1;
         end
         reset_init_pkg::RC_WAKE_IRQ: begin
            // only cause flags and the vector path change on wake-up
            st_next.pir_flags = (st_next.pir_flags | {1'b0, wake_irq_source})
                                & `PIR_FLAGS_MASK;
            if (wake_irq_source == 7'h0) begin
               st_next.int_ctrl[`WAKE_FLAG_BIT] = 1'b1;
            end
            if (st_reg.int_ctrl[`HIGH_GLOBAL_IRQ_ENABLE_BIT] || st_reg.int_ctrl[`LOW_GLOBAL_IRQ_ENABLE_BIT]) begin
               st_next.prog_cnt = wake_irq_high ? `VEC_HIGH : `VEC_LOW;
               st_next.tos      = st_reg.prog_cnt;
               // saturates at the top instead of wrapping silently
               if (st_reg.stk_ptr != `STACK_DEPTH_MAX) begin
                  st_next.stk_ptr = st_reg.stk_ptr + 5'h1;
               end
            end
            evt_set[`EVT_WAKE_IRQ] = 1'b1;
         end
         reset_init_pkg::RC_WAKE_WDT: begin
            evt_set[`EVT_WAKE_WDT] = 1'b1;
         end
         default: ;
      endcase

      // sticky events: a set in the clearing cycle wins
      st_next.evt_status = ((st_reg.evt_status & ~evt_clr) | evt_set) & `EVT_MASK_BITS;
      st_next.irq        = |(st_next.evt_status & st_next.evt_mask);

      // bus side of reset: channels idle, bank already loaded above
      if (!aresetn) begin
         st_next.evt_status = 8'h0;
         st_next.evt_mask   = 8'h0;
         st_next.irq        = 1'b0;
         st_next.pin        = '0;
         st_next.e_pin      = 4'h0;
         st_next.aw_held    = 1'b0;
         st_next.aw_addr    = 8'h0;
         st_next.w_held     = 1'b0;
         st_next.w_data     = 32'h0;
         st_next.w_strb     = 4'h0;
         st_next.awready    = 1'b0;
         st_next.wready     = 1'b0;
         st_next.bvalid     = 1'b0;
         st_next.bresp      = `RESP_OKAY;
         st_next.arready    = 1'b0;
         st_next.rvalid     = 1'b0;
         st_next.rdata      = 32'h0;
         st_next.rresp      = `RESP_OKAY;
         st_next.lat        = '0;
         st_next.e_lat      = 3'h0;
      end
   end

   // single state register; reset folded in the comb block
   always_ff @(posedge aclk) begin
      st_reg <= st_next;
   end

   // every output straight from the state register
   assign s_axi_awready        = st_reg.awready;
   assign s_axi_wready         = st_reg.wready;
   assign s_axi_bresp          = st_reg.bresp;
   assign s_axi_bvalid         = st_reg.bvalid;
   assign s_axi_arready        = st_reg.arready;
   assign s_axi_rdata          = st_reg.rdata;
   assign s_axi_rresp          = st_reg.rresp;
   assign s_axi_rvalid         = st_reg.rvalid;
   assign port_direction       = st_reg.dir;
   assign port_latch           = st_reg.lat;
   assign port_e_direction     = st_reg.e_dir;
   assign port_e_latch         = st_reg.e_lat;
   assign program_counter      = st_reg.prog_cnt;
   assign return_stack_pointer = st_reg.stk_ptr;
   assign irq                  = st_reg.irq;

endmodule // reset_init_values_bank

`default_nettype wire

// ---- tb/reset_init_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module reset_init_checker (
   input wire logic            aclk,                 // clock
   input wire logic            aresetn,              // reset
   input wire logic            power_on_reset,       // cold
   input wire logic            warm_reset,           // warm
   input wire logic            wake_watchdog,        // wdt wake
   input wire logic            wake_interrupt,       // irq wake
   input wire logic            wake_irq_high,        // vector pick
   input wire logic [3:0][7:0] port_direction,       // dirs
   input wire logic [20:0]     program_counter,      // pc
   input wire logic [4:0]      return_stack_pointer, // sp
   input wire logic            s_axi_rvalid,         // read valid
   input wire logic            s_axi_rready          // read ready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // lower classes lose to any reset in the same cycle
   wire logic any_rst = power_on_reset || warm_reset;
   wire logic wk      = wake_interrupt && !any_rst;
   chk_cold_dir: assert property (
      power_on_reset |=> port_direction == {4{8'hff}}) else $error("dir after cold");
   chk_warm_dir: assert property (
      warm_reset |=> port_direction == {4{8'hff}}) else $error("dir after warm");
   chk_rst_pc: assert property (
      any_rst |=> program_counter == 21'h0 && return_stack_pointer == 5'h0) else $error("pc/sp");
   chk_wdt_keep: assert property (
      wake_watchdog && !wake_interrupt && !any_rst |=> $stable(program_counter)
         && $stable(return_stack_pointer)) else $error("wdt wake moved pc");
   chk_irq_vec: assert property (
      wk |=> $stable(program_counter) || program_counter ==
         ($past(wake_irq_high) ? 21'h8 : 21'h18)) else $error("bad vector");
   chk_sp_step: assert property (
      wk ##1 $changed(program_counter) |-> return_stack_pointer ==
         $past(return_stack_pointer) + 5'h1) else $error("sp not advanced");
   chk_pc_quiet: assert property (
      !wk && !any_rst |=> $stable(program_counter)) else $error("pc moved idle");
   chk_rd_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
   cover property (wk);
   cover property (warm_reset);
   cover property (power_on_reset);
endmodule // reset_init_checker
bind reset_init_values_bank reset_init_checker i_chk (.aclk(aclk), .aresetn(aresetn),
   .power_on_reset(power_on_reset), .warm_reset(warm_reset), .wake_watchdog(wake_watchdog),
   .wake_interrupt(wake_interrupt), .wake_irq_high(wake_irq_high),
   .port_direction(port_direction), .program_counter(program_counter),
   .return_stack_pointer(return_stack_pointer), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));
`default_nettype wire

// ---- tb/class_source_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module class_source_model (
   input  wire logic       aclk,          // clock
   input  wire logic [2:0] kind,          // class asked for, 0 = none
   output logic [4:0]      pulse = 5'h0,  // one-hot class pulse
   output logic [3:0][7:0] pins,          // port a..d levels
   output logic [3:0]      pins_e         // port e levels
);
   // pins all high so forced-zero bits stand out
   assign pins   = {4{8'hff}};
   assign pins_e = 4'hf;
   // request is registered into the pulse, which lasts as long as the request
   always @(posedge aclk) pulse <= (kind == 3'h0) ? 5'h0 : (5'h1 << kind);
endmodule // class_source_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0;
   logic rre = 1'h0, hi = 1'h0, osc = 1'h1, xr = 1'h1, awr, wr_, bv, arr, rv, irq;
   logic [7:0] aw = 8'h0, ar = 8'h0;
   logic [31:0] wd = 32'h0, rdat;
   logic [1:0] br, rr;
   logic [6:0] src = 7'h0;
   logic [2:0] kind = 3'h0;
   logic [4:0] pul, sp;
   logic [3:0][7:0] pins, dir, lat;
   logic [3:0] pe;
   logic [20:0] pc;
   logic [2:0] ped, pel;
   int mismatches = 0, n_compared = 0, cyc = 0;
   reset_init_values_bank i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .power_on_reset(pul[1]), .warm_reset(pul[2]), .wake_watchdog(pul[3]),
      .wake_interrupt(pul[4]), .wake_irq_high(hi), .wake_irq_source(src),
      .osc_pins_enable(osc), .external_reset_pin_enable(xr), .port_pins_in(pins),
      .port_e_pins_in(pe), .port_direction(dir), .port_latch(lat), .port_e_direction(ped),
      .port_e_latch(pel), .program_counter(pc), .return_stack_pointer(sp), .irq(irq));
   class_source_model i_src (.aclk(aclk), .kind(kind), .pulse(pul), .pins(pins),
      .pins_e(pe));
   initial forever #5 aclk = ~aclk;
   // whole run needs well under 2000 cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      aw <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bre <= 1'h1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'h0;
         if (wr_) wv <= 1'h0;
      end while (!bv);
      bre <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      ar <= a;
      arv <= 1'h1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'h0;
      end while (!rv);
      // stall one cycle so rvalid must stand
      rre <= 1'h1;
      @(posedge aclk);
      rre <= 1'h0;
      chk(rdat, e);
      chk({30'h0, rr}, {30'h0, er});
   endtask
   // class pulse lands one edge after the request
   task automatic fire(input logic [2:0] k);
      @(posedge aclk);
      kind <= k;
      @(posedge aclk);
      kind <= 3'h0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic t_cold;
      rd(8'h00, 32'hff, 2'h0);
      rd(8'h30, 32'h7, 2'h0);
      chk({29'h0, ped}, 32'h7);
      rd(8'h54, 32'h7f, 2'h0);
      rd(8'h40, 32'hffff, 2'h0);
      rd(8'hfc, 32'h0, 2'h2);
   endtask
   task automatic t_pins;
      rd(8'h08, 32'hd0, 2'h0);
      rd(8'h38, 32'h7, 2'h0);
      osc <= 1'h0;
      xr <= 1'h0;
      wr(8'h3c, 32'hffffffff);
      rd(8'h3c, 32'h3f, 2'h0);
      rd(8'h08, 32'h10, 2'h0);
      rd(8'h38, 32'hf, 2'h0);
      wr(8'h04, 32'hff);
      rd(8'h04, 32'h3f, 2'h0);
      osc <= 1'h1;
   endtask
   task automatic t_warm;
      wr(8'h10, 32'h5a);
      wr(8'h0c, 32'h0);
      wr(8'h34, 32'h5);
      fire(3'h2);
      rd(8'h0c, 32'hff, 2'h0);
      rd(8'h10, 32'h5a, 2'h0);
      chk({24'h0, lat[1]}, 32'h5a);
      chk({29'h0, pel}, 32'h5);
   endtask
   task automatic t_wake;
      wr(8'h48, 32'h80);
      chk({31'h0, irq}, 32'h0);
      wr(8'h68, 32'h8);
      hi <= 1'h1;
      src <= 7'h1;
      fire(3'h4);
      chk({11'h0, pc}, 32'h8);
      chk({27'h0, sp}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd(8'h4c, 32'h1, 2'h0);
      rd(8'h5c, 32'h0, 2'h0);
      hi <= 1'h0;
      fire(3'h4);
      chk({11'h0, pc}, 32'h18);
      rd(8'h5c, 32'h8, 2'h0);
      fire(3'h3);
      chk({27'h0, sp}, 32'h2);
      rd(8'h10, 32'h5a, 2'h0);
      wr(8'h64, 32'h8);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_por;
      fire(3'h1);
      rd(8'h10, 32'h0, 2'h0);
      chk({24'h0, lat[1]}, 32'h0);
      chk({29'h0, pel}, 32'h0);
      chk({27'h0, sp}, 32'h0);
   endtask
   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      t_cold();
      t_pins();
      t_warm();
      t_wake();
      t_por();
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
